// File: tpw_pkg.sv
package tpw_pkg;
  // Function
  // RULE1: Fast mode counts to top, then wraps
  // RULE2: Fast mode sets overflow flag at top
  // RULE3: Fast mode: two non-inverted, three inverted
  // RULE4: Mode three top 0xFF, seven compare A
  // RULE5: Fast output flips at match, back at wrap
  // RULE6: Compare zero spikes, compare max holds level
  // RULE7: Mode one toggles output on each match; code toggles only in the fast modes
  // RULE8: Fast mode compare value is double buffered
  // RULE9: Modes one, five dual slope; 0xFF, compare A
  // RULE10: Dual slope holds top one tick, reverses
  // RULE11: Up match clears, down match sets output
  // RULE12: Dual slope sets overflow flag at zero
  // RULE13: Dual slope: two non-inverted, three inverted
  // RULE14: Dual slope compare zero low, max high
  // RULE15: Leaving max still gives symmetric transition
  // RULE16: Missed up match still forces its transition
  // RULE17: Tick enables bus clock, or oscillator pin
  // RULE18: Tick prescales by 1 to 1024
  // RULE19: Output mode zero leaves output alone
  // RULE20: Counter write blocks matches one tick
  // RULE21: Buffer loads at top dual, zero fast

  // Register byte addresses
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_COUNTER = 8'h04;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h08;
  localparam logic [7:0] ADDR_COMPARE_B = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;

  // Control field positions
  localparam int CTRL_COM_A_LSB = 0;
  localparam int CTRL_COM_B_LSB = 2;
  localparam int CTRL_WAVE_LSB = 4;
  localparam int CTRL_CLKSEL_LSB = 7;
  localparam int CTRL_ASYNC_BIT = 10;
  localparam int CTRL_WIDTH = 11;

  // Status bit positions
  localparam int STAT_OVERFLOW = 0;
  localparam int STAT_COMPARE_A = 1;
  localparam int STAT_COMPARE_B = 2;

  // Reset values
  localparam logic [10:0] CONTROL_RESET = 11'h000;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COMPARE_RESET = 8'h00;
  localparam logic [7:0] TOP_FIXED = 8'hFF;

  // Waveform mode low bits and top select bit
  localparam logic [1:0] WAVE_FAST = 2'h3;
  localparam logic [1:0] WAVE_PHASE = 2'h1;
  localparam int WAVE_TOP_SEL = 2;

  // Compare output modes
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;

  // Clock select codes and prescale masks
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV32 = 3'h3;
  localparam logic [2:0] CS_DIV64 = 3'h4;
  localparam logic [2:0] CS_DIV128 = 3'h5;
  localparam logic [2:0] CS_DIV256 = 3'h6;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV32 = 10'h01F;
  localparam logic [9:0] MASK_DIV64 = 10'h03F;
  localparam logic [9:0] MASK_DIV128 = 10'h07F;
  localparam logic [9:0] MASK_DIV256 = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
endpackage

// File: tpw_prescaler.sv
module tpw_prescaler (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Source enable and selection
  input wire logic src_en,
  input wire logic [2:0] clock_select,
  // Prescaled tick
  output logic timer_tick
);
  logic [9:0] div_count;
  logic [9:0] next_div_count;
  logic [9:0] mask;

  // Mask of low bits that must all be set for a tick
  always_comb begin
    case (clock_select)
      tpw_pkg::CS_DIV8: mask = tpw_pkg::MASK_DIV8;
      tpw_pkg::CS_DIV32: mask = tpw_pkg::MASK_DIV32;
      tpw_pkg::CS_DIV64: mask = tpw_pkg::MASK_DIV64;
      tpw_pkg::CS_DIV128: mask = tpw_pkg::MASK_DIV128;
      tpw_pkg::CS_DIV256: mask = tpw_pkg::MASK_DIV256;
      tpw_pkg::CS_DIV1: mask = 10'h000;
      default: mask = tpw_pkg::MASK_DIV1024;
    endcase
  end

  // Free running divider, stopped selection gives no tick
  always_comb begin
    next_div_count = div_count;
    if (src_en) begin
      next_div_count = div_count + 10'h001;
    end
    timer_tick = src_en && (clock_select != tpw_pkg::CS_STOP)
                 && ((div_count & mask) == mask); // RULE18
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 10'h000;
    end else begin
      div_count <= next_div_count;
    end
  end
endmodule // tpw_prescaler

// File: tpw_compare_out.sv
module tpw_compare_out (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Timer state
  input wire logic timer_tick,
  input wire logic fast,
  input wire logic phase,
  input wire logic count_up,
  input wire logic at_top,
  input wire logic at_bottom,
  input wire logic match,
  input wire logic compare_zero,
  input wire logic compare_top,
  input wire logic [1:0] compare_output_mode,
  // Output register
  output logic compare_output
);
  logic next_output;
  logic inverted;
  logic up_level;
  logic down_level;

  // Up match drives the passive level, down match the active one
  always_comb begin
    inverted = compare_output_mode[0]; // RULE3 RULE13
    up_level = inverted;
    down_level = !inverted;
    next_output = compare_output;
    if (timer_tick && compare_output_mode != tpw_pkg::COM_OFF) begin // RULE19
      if (compare_output_mode == tpw_pkg::COM_TOGGLE) begin
        if (fast && match) begin
          next_output = !compare_output; // RULE7
        end
      end else if (fast) begin
        // Wrap wins so compare at top holds a steady level
        if (at_top) begin
          next_output = !inverted; // RULE5 RULE6
        end else if (match) begin
          next_output = inverted; // RULE5
        end
      end else if (phase) begin
        // Turnarounds force the level a match would give
        if (at_top) begin
          next_output = compare_top ? down_level : up_level; // RULE15 RULE14
        end else if (at_bottom) begin
          next_output = compare_zero ? up_level : down_level; // RULE16 RULE14
        end else if (match) begin
          next_output = count_up ? up_level : down_level; // RULE11
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_output <= 1'b0;
    end else begin
      compare_output <= next_output;
    end
  end

  a_toggle_match: assert property (@(posedge pclk) disable iff (!presetn)
    (timer_tick && fast && match && compare_output_mode == tpw_pkg::COM_TOGGLE)
    |=> (compare_output != $past(compare_output))) // RULE7
    else $error("toggle mode missed a match");

  a_mode_off: assert property (@(posedge pclk) disable iff (!presetn)
    (compare_output_mode == tpw_pkg::COM_OFF) |=> $stable(compare_output)) // RULE19
    else $error("output moved with mode off");
endmodule // tpw_compare_out

// File: tpw_timer.sv
module tpw_timer (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Oscillator pin for asynchronous operation
  input wire logic osc_pin,
  // Compare outputs and port override enables
  output logic compare_output_a,
  output logic compare_output_b,
  output logic compare_drive_a,
  output logic compare_drive_b
);
  // Register state
  logic [10:0] control;
  logic [7:0] counter_value;
  logic [7:0] compare_a_buf;
  logic [7:0] compare_b_buf;
  logic [7:0] compare_a_value;
  logic [7:0] compare_b_value;
  logic [2:0] status;
  logic count_up;
  logic match_block;
  logic [10:0] next_control;
  logic [7:0] next_counter_value;
  logic [7:0] next_compare_a_buf;
  logic [7:0] next_compare_b_buf;
  logic [7:0] next_compare_a_value;
  logic [7:0] next_compare_b_value;
  logic [2:0] next_status;
  logic next_count_up;
  logic next_match_block;
  // Bus state
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [31:0] read_mux;
  logic hit;
  logic wr_commit;
  // Oscillator synchroniser
  logic [2:0] osc_sync;
  logic osc_level;
  logic [2:0] next_osc_sync;
  logic next_osc_level;
  logic osc_rise;
  // Output override enables
  logic next_drive_a;
  logic next_drive_b;
  // Decoded timer state
  logic [1:0] com_a;
  logic [1:0] com_b;
  logic [2:0] waveform_mode;
  logic [2:0] clock_select;
  logic async_select;
  logic fast;
  logic phase;
  logic [7:0] top;
  logic at_top;
  logic at_bottom;
  logic match_a;
  logic match_b;
  logic load_compare;
  logic src_en;
  logic timer_tick;

  // Control fields
  always_comb begin
    com_a = control[tpw_pkg::CTRL_COM_A_LSB +: 2];
    com_b = control[tpw_pkg::CTRL_COM_B_LSB +: 2];
    waveform_mode = control[tpw_pkg::CTRL_WAVE_LSB +: 3];
    clock_select = control[tpw_pkg::CTRL_CLKSEL_LSB +: 3];
    async_select = control[tpw_pkg::CTRL_ASYNC_BIT];
  end

  // Oscillator pin: three stages, edge once stages two and three agree
  always_comb begin
    next_osc_sync = {osc_sync[1:0], osc_pin};
    next_osc_level = osc_level;
    if (osc_sync[1] == osc_sync[2]) begin
      next_osc_level = osc_sync[2];
    end
    osc_rise = (osc_sync[1] == osc_sync[2]) && osc_sync[2] && !osc_level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sync <= 3'h0;
      osc_level <= 1'b0;
    end else begin
      osc_sync <= next_osc_sync;
      osc_level <= next_osc_level;
    end
  end

  // Tick source: every bus clock, or each oscillator rising edge
  assign src_en = async_select ? osc_rise : 1'b1; // RULE17

  tpw_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_en(src_en),
    .clock_select(clock_select),
    .timer_tick(timer_tick)
  );

  // Mode decode and top selection
  always_comb begin
    fast = (waveform_mode[1:0] == tpw_pkg::WAVE_FAST); // RULE4
    phase = (waveform_mode[1:0] == tpw_pkg::WAVE_PHASE); // RULE9
    top = waveform_mode[tpw_pkg::WAVE_TOP_SEL] ? compare_a_value
                                               : tpw_pkg::TOP_FIXED; // RULE4 RULE9
    // Greater-or-equal recovers if top is lowered under the count
    at_top = phase ? (count_up && counter_value >= top) : (counter_value >= top);
    at_bottom = phase && !count_up && (counter_value == 8'h00);
    match_a = timer_tick && !match_block && (counter_value == compare_a_value); // RULE20
    match_b = timer_tick && !match_block && (counter_value == compare_b_value); // RULE20
    // Buffers load at the period boundary only in the PWM modes
    load_compare = (fast || phase) ? (timer_tick && at_top) : 1'b1; // RULE8 RULE21
  end

  // APB decode and read data
  always_comb begin
    hit = 1'b1;
    read_mux = 32'h0000_0000;
    case (paddr)
      tpw_pkg::ADDR_CONTROL: read_mux = {21'h000000, control};
      tpw_pkg::ADDR_COUNTER: read_mux = {24'h000000, counter_value};
      tpw_pkg::ADDR_COMPARE_A: read_mux = {24'h000000, compare_a_buf};
      tpw_pkg::ADDR_COMPARE_B: read_mux = {24'h000000, compare_b_buf};
      tpw_pkg::ADDR_STATUS: read_mux = {29'h00000000, status};
      default: hit = 1'b0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_comb begin
    wr_commit = psel && penable && pready && pwrite && hit;
    next_pready = psel && penable && !pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_prdata = pwrite ? 32'h0000_0000 : read_mux;
      next_pslverr = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // Software registers; compare writes land in the buffers
  always_comb begin
    next_control = control;
    next_compare_a_buf = compare_a_buf;
    next_compare_b_buf = compare_b_buf;
    if (wr_commit && paddr == tpw_pkg::ADDR_CONTROL) begin
      next_control = pwdata[tpw_pkg::CTRL_WIDTH-1:0];
    end
    if (wr_commit && paddr == tpw_pkg::ADDR_COMPARE_A) begin
      next_compare_a_buf = pwdata[7:0]; // RULE8
    end
    if (wr_commit && paddr == tpw_pkg::ADDR_COMPARE_B) begin
      next_compare_b_buf = pwdata[7:0];
    end
    next_drive_a = (next_control[tpw_pkg::CTRL_COM_A_LSB +: 2] != tpw_pkg::COM_OFF);
    next_drive_b = (next_control[tpw_pkg::CTRL_COM_B_LSB +: 2] != tpw_pkg::COM_OFF);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control <= tpw_pkg::CONTROL_RESET;
      compare_a_buf <= tpw_pkg::COMPARE_RESET;
      compare_b_buf <= tpw_pkg::COMPARE_RESET;
      compare_drive_a <= 1'b0;
      compare_drive_b <= 1'b0;
    end else begin
      control <= next_control;
      compare_a_buf <= next_compare_a_buf;
      compare_b_buf <= next_compare_b_buf;
      compare_drive_a <= next_drive_a;
      compare_drive_b <= next_drive_b;
    end
  end

  // Counter, direction, active compare values and match blocking
  always_comb begin
    next_counter_value = counter_value;
    next_count_up = count_up;
    next_match_block = match_block;
    next_compare_a_value = compare_a_value;
    next_compare_b_value = compare_b_value;
    if (load_compare) begin
      next_compare_a_value = compare_a_buf; // RULE21
      next_compare_b_value = compare_b_buf; // RULE21
    end
    if (timer_tick) begin
      next_match_block = 1'b0;
      if (phase) begin
        if (count_up) begin
          if (at_top) begin
            // Top was held for this tick, now head down
            next_count_up = 1'b0; // RULE10
            next_counter_value = (counter_value == 8'h00) ? 8'h00
                                                          : counter_value - 8'h01;
          end else begin
            next_counter_value = counter_value + 8'h01;
          end
        end else if (counter_value == 8'h00) begin
          next_count_up = 1'b1;
          next_counter_value = 8'h01;
        end else begin
          next_counter_value = counter_value - 8'h01;
        end
      end else begin
        next_count_up = 1'b1;
        next_counter_value = at_top ? 8'h00 : counter_value + 8'h01; // RULE1
      end
    end
    // A software write overrides the tick and mutes the next matches
    if (wr_commit && paddr == tpw_pkg::ADDR_COUNTER) begin
      next_counter_value = pwdata[7:0];
      next_match_block = 1'b1; // RULE20
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= tpw_pkg::COUNTER_RESET;
      count_up <= 1'b1;
      match_block <= 1'b0;
      compare_a_value <= tpw_pkg::COMPARE_RESET;
      compare_b_value <= tpw_pkg::COMPARE_RESET;
    end else begin
      counter_value <= next_counter_value;
      count_up <= next_count_up;
      match_block <= next_match_block;
      compare_a_value <= next_compare_a_value;
      compare_b_value <= next_compare_b_value;
    end
  end

  // Sticky flags, write one to clear; a new event beats the clear
  always_comb begin
    next_status = status;
    if (wr_commit && paddr == tpw_pkg::ADDR_STATUS) begin
      next_status = status & ~pwdata[2:0];
    end
    if (timer_tick && (phase ? at_bottom : at_top)) begin
      next_status[tpw_pkg::STAT_OVERFLOW] = 1'b1; // RULE2 RULE12
    end
    if (match_a) begin
      next_status[tpw_pkg::STAT_COMPARE_A] = 1'b1;
    end
    if (match_b) begin
      next_status[tpw_pkg::STAT_COMPARE_B] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 3'h0;
    end else begin
      status <= next_status;
    end
  end

  // Compare output units; each channel reaches top when above it too
  tpw_compare_out u_out_a (
    .pclk(pclk),
    .presetn(presetn),
    .timer_tick(timer_tick),
    .fast(fast),
    .phase(phase),
    .count_up(count_up),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .match(match_a),
    .compare_zero(compare_a_value == 8'h00),
    .compare_top(compare_a_value >= top),
    .compare_output_mode(com_a),
    .compare_output(compare_output_a)
  );

  tpw_compare_out u_out_b (
    .pclk(pclk),
    .presetn(presetn),
    .timer_tick(timer_tick),
    .fast(fast),
    .phase(phase),
    .count_up(count_up),
    .at_top(at_top),
    .at_bottom(at_bottom),
    .match(match_b),
    .compare_zero(compare_b_value == 8'h00),
    .compare_top(compare_b_value >= top),
    .compare_output_mode(com_b),
    .compare_output(compare_output_b)
  );

  // Checks on counting, flags and buffering
  a_fast_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    (timer_tick && fast && at_top && !wr_commit) |=> (counter_value == 8'h00))
    else $error("fast mode did not wrap at top");

  a_fast_overflow: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (timer_tick && fast && counter_value == top) |=> status[tpw_pkg::STAT_OVERFLOW])
    else $error("fast overflow flag not set");

  a_phase_turn: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (timer_tick && phase && count_up && counter_value == top && top != 8'h00
     && !wr_commit) |=> (!count_up && counter_value == $past(counter_value) - 8'h01))
    else $error("dual slope did not turn at top");

  a_phase_overflow: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    (timer_tick && phase && !count_up && counter_value == 8'h00)
    |=> (status[tpw_pkg::STAT_OVERFLOW] && count_up))
    else $error("dual slope overflow flag not set at zero");

  a_buffer_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (fast && !(timer_tick && at_top)) |=> $stable(compare_a_value))
    else $error("active compare changed mid period");

  a_block_match: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
    (wr_commit && paddr == tpw_pkg::ADDR_COUNTER) |=> !match_a until_with timer_tick)
    else $error("match not blocked after counter write");

  a_tick_stop: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (clock_select == tpw_pkg::CS_STOP) |-> !timer_tick)
    else $error("tick with clock stopped");
endmodule // tpw_timer

// File: tpw_load.sv
module tpw_load (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin as seen from the board
  input wire logic level,
  input wire logic drive,
  // Measurement control and result
  input wire logic clear,
  output logic [15:0] high_count
);
  timeunit 1ns;
  timeprecision 1ns;

  logic pin;
  logic [15:0] next_high_count;

  // Pull-down on the board: a released pin reads low, never the last level
  assign pin = drive & level;

  // Count cycles the pin spends high since the last clear
  always_comb begin
    next_high_count = high_count;
    if (clear) begin
      next_high_count = 16'h0000;
    end else if (pin) begin
      next_high_count = high_count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_count <= 16'h0000;
    end else begin
      high_count <= next_high_count;
    end
  end
endmodule // tpw_load

// File: tpw_timer_bench.sv
module tpw_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic osc_pin = 1'b0;
  logic osc_run = 1'b0;
  logic [2:0] osc_div = 3'h0;
  logic out_a, out_b, drive_a, drive_b;
  logic clear = 1'b0;
  logic [15:0] count_a, count_b;
  int fail_count = 0;
  int n_checks = 0;

  // Clock at 10 MHz
  always #50 pclk = ~pclk;

  // Oscillator pin: eight bus clocks a period, still while not running
  always @(posedge pclk) begin
    if (osc_run) begin
      osc_div <= osc_div + 3'h1;
      osc_pin <= osc_div[2];
    end
  end

  tpw_timer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_pin(osc_pin), .compare_output_a(out_a),
    .compare_output_b(out_b), .compare_drive_a(drive_a), .compare_drive_b(drive_b));
  tpw_load u_load_a (.pclk(pclk), .presetn(presetn), .level(out_a), .drive(drive_a),
    .clear(clear), .high_count(count_a));
  tpw_load u_load_b (.pclk(pclk), .presetn(presetn), .level(out_b), .drive(drive_b),
    .clear(clear), .high_count(count_b));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One APB transfer; starts and ends just after a rising edge, idle between
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      $display("[ERR] pready expected 1 seen timeout");
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
  endtask

  // Stop, rewind, load compares while stopped (buffer loads at once), then run
  task automatic cfg(input logic [2:0] wave, input logic [1:0] com_a, input logic [1:0] com_b,
                     input logic [2:0] cs, input logic [7:0] a, input logic [7:0] b);
    wr(tpw_pkg::ADDR_CONTROL, 32'h0000_0000);
    wr(tpw_pkg::ADDR_COUNTER, 32'h0000_0000);
    wr(tpw_pkg::ADDR_COMPARE_A, {24'h000000, a});
    wr(tpw_pkg::ADDR_COMPARE_B, {24'h000000, b});
    wr(tpw_pkg::ADDR_STATUS, 32'h0000_0007);
    wr(tpw_pkg::ADDR_CONTROL, {21'h000000, 1'b0, cs, wave, com_b, com_a});
  endtask

  // Skip one window to settle, then count high cycles over exactly one window
  task automatic measure(input string what, input logic sel_b, input int win,
                         input logic [31:0] exp);
    repeat (win) @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (win) @(posedge pclk);
    #1;
    check(what, {16'h0000, sel_b ? count_b : count_a}, exp);
  endtask

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(tpw_pkg::ADDR_CONTROL, q);
    check("control reset", q, 32'h0000_0000);
    rd(tpw_pkg::ADDR_COMPARE_A, q);
    check("compare a reset", q, 32'h0000_0000);
    wr(tpw_pkg::ADDR_COMPARE_B, 32'h0000_005A);
    rd(tpw_pkg::ADDR_COMPARE_B, q);
    check("compare b readback", q, 32'h0000_005A);
    apb(1'b0, 8'h14, 32'h0000_0000, q, e);
    check("unmapped error", {31'h0, e}, 32'h0000_0001);
    check("unmapped data", q, 32'h0000_0000);
    $display("test regs done");
  endtask

  task automatic t_fast();
    logic [31:0] q;
    logic [7:0] vals [3] = '{8'h00, 8'h64, 8'hFF};
    for (int m = 2; m <= 3; m++) begin
      foreach (vals[i]) begin
        cfg(3'h3, m[1:0], 2'h0, tpw_pkg::CS_DIV1, vals[i], 8'h00);
        measure("fast duty", 1'b0, 256, m == 2 ? vals[i] + 1 : 255 - vals[i]);
        check("fast drive", {31'h0, drive_a}, 32'h0000_0001);
        rd(tpw_pkg::ADDR_STATUS, q);
        check("fast overflow", q & 32'h1, 32'h0000_0001);
      end
    end
    $display("test fast done");
  endtask

  task automatic t_phase();
    logic [7:0] vals [3] = '{8'h00, 8'h64, 8'hFF};
    for (int m = 2; m <= 3; m++) begin
      foreach (vals[i]) begin
        cfg(3'h1, m[1:0], 2'h0, tpw_pkg::CS_DIV1, vals[i], 8'h00);
        measure("phase duty", 1'b0, 510, m == 2 ? 2 * vals[i] : 510 - 2 * vals[i]);
      end
    end
    $display("test phase done");
  endtask

  task automatic t_top();
    logic [31:0] q;
    // Top from compare A: period A+1 single slope, 2A dual slope
    cfg(3'h7, 2'h0, 2'h2, tpw_pkg::CS_DIV1, 8'h63, 8'h1E);
    measure("mode 7 duty", 1'b1, 100, 31);
    check("com off drive", {31'h0, drive_a}, 32'h0000_0000);
    check("com b drive", {31'h0, drive_b}, 32'h0000_0001);
    cfg(3'h5, 2'h0, 2'h2, tpw_pkg::CS_DIV1, 8'h32, 8'h14);
    measure("mode 5 duty", 1'b1, 100, 40);
    rd(tpw_pkg::ADDR_STATUS, q);
    check("phase overflow", q & 32'h1, 32'h0000_0001);
    // Toggle on each match: half of two wraps high
    cfg(3'h3, 2'h1, 2'h0, tpw_pkg::CS_DIV1, 8'h0A, 8'h00);
    measure("toggle duty", 1'b0, 512, 256);
    $display("test top done");
  endtask

  task automatic t_presc();
    int n;
    // Spike at compare zero lasts one tick, stretched by the prescale factor
    for (int s = 1; s <= 3; s++) begin
      n = (s == 1) ? 1 : (s == 2) ? 8 : 32;
      cfg(3'h3, 2'h2, 2'h0, s[2:0], 8'h00, 8'h00);
      measure("prescaled spike", 1'b0, 256 * n, n);
    end
    // Slow selections with top 3 on channel B keep the windows short
    for (int s = 4; s <= 7; s++) begin
      n = (s == 7) ? 1024 : 1 << (s + 2);
      cfg(3'h7, 2'h0, 2'h2, s[2:0], 8'h03, 8'h00);
      measure("prescaled spike top", 1'b1, 4 * n, n);
    end
    $display("test presc done");
  endtask

  task automatic t_missed();
    // Park the output high, then jump above the compare on the way up
    cfg(3'h1, 2'h2, 2'h0, tpw_pkg::CS_DIV1, 8'hFF, 8'h00);
    repeat (510) @(posedge pclk);
    cfg(3'h1, 2'h2, 2'h0, tpw_pkg::CS_DIV8, 8'h64, 8'h00);
    // Two ticks first, so the count is surely heading up
    repeat (16) @(posedge pclk);
    wr(tpw_pkg::ADDR_COUNTER, 32'h0000_00C8);
    // Past top, still above the compare on the way down
    repeat (700) @(posedge pclk);
    #1;
    check("missed match", {31'h0, out_a}, 32'h0000_0000);
    $display("test missed done");
  endtask

  task automatic t_async();
    // Oscillator edges as tick source: ten ticks of eight clocks, five high
    osc_run <= 1'b1;
    cfg(3'h7, 2'h0, 2'h2, tpw_pkg::CS_DIV1, 8'h09, 8'h04);
    wr(tpw_pkg::ADDR_CONTROL, {21'h000000, 1'b1, tpw_pkg::CS_DIV1, 3'h7, 2'h2, 2'h0});
    measure("async duty", 1'b1, 160, 80);
    osc_run <= 1'b0;
    $display("test async done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_fast();
    t_phase();
    t_top();
    t_presc();
    t_missed();
    t_async();
    finish_test();
  end

  // Watchdog well beyond the expected run of some 50000 cycles
  initial begin
    #8000000;
    fail_count++;
    finish_test();
  end
endmodule // tpw_timer_bench
